// ===== rtl/hdbp_top.sv
// Host DMA buffer port: DMA handshake, bus FIFOs, control registers on Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "hdbp_params.svh"
module hdbp_top
  import hdbp_pkg::*;
#(
  parameter int DW = 16,
  parameter int BAW = 16,
  parameter int FAW = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host DMA pins
  output logic dma_req,
  input wire logic dma_ack,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic dma_end_status,
  output logic chan_ready,
  input wire logic [DW-1:0] host_data_in,
  output logic [DW-1:0] host_data_out,
  output logic host_data_oe,
  // Packet buffer memory
  output logic buf_wr_en,
  output logic [BAW-1:0] buf_wr_addr,
  output logic [DW-1:0] buf_wr_data,
  output logic buf_rd_en,
  output logic [BAW-1:0] buf_rd_addr,
  input wire logic [DW-1:0] buf_rd_data,
  // Controller side
  input wire logic rx_packet_waiting,
  output logic tx_start,
  output logic [6:0] transmit_packet_count,
  output logic dma_end_irq
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [1:0] dma_enable_reg;
  logic [1:0] dma_burst_reg;
  logic [6:0] tx_count_reg;
  logic tx_start_reg;
  logic dma_end_status_reg;
  logic dma_end_int_enable_reg;
  logic request_extend_reg;
  logic [1:0] config_reg;
  logic wb_ack_reg;
  logic [31:0] wb_dat_reg;

  // ----------------------------------------------------------------
  // DMA datapath state
  // ----------------------------------------------------------------
  logic wr_taken_reg;
  logic rd_loaded_reg;
  logic eop_seen_reg;
  logic [DW-1:0] host_data_reg;
  logic buf_wr_en_reg;
  logic [BAW-1:0] buf_wr_addr_reg;
  logic [DW-1:0] buf_wr_data_reg;
  logic buf_rd_en_reg;
  logic [BAW-1:0] buf_rd_addr_reg;

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  wire wb_req = wb_cyc_i & wb_stb_i;
  wire wb_take = wb_req & ~wb_ack_reg;
  wire wb_wr = wb_take & wb_we_i & wb_sel_i[0];
  wire hit_en = wb_adr_i == `HDBP_OFS_DMA_ENABLE;
  wire hit_burst = wb_adr_i == `HDBP_OFS_DMA_BURST;
  wire hit_txs = wb_adr_i == `HDBP_OFS_TX_START;
  wire hit_stat = wb_adr_i == `HDBP_OFS_RX_STATUS;
  wire hit_ien = wb_adr_i == `HDBP_OFS_RX_INT_EN;
  wire hit_txm = wb_adr_i == `HDBP_OFS_TX_MODE;
  wire hit_rxm = wb_adr_i == `HDBP_OFS_RX_MODE;
  wire hit_cfg = wb_adr_i == `HDBP_OFS_CONFIG;
  wire [1:0] en_wdat = {wb_dat_i[`HDBP_BIT_RX_EN], wb_dat_i[`HDBP_BIT_TX_EN]};
  wire en_write = wb_wr & hit_en;

  // An enable falling, or both written as zero, restarts the DMA logic
  wire en_fall = |(dma_enable_reg & ~en_wdat);
  wire dma_reset = en_write & (en_fall | (en_wdat == `HDBP_RST_EN)); // [RQ9] [RQ19]
  wire ien_fall = wb_wr & hit_ien & dma_end_int_enable_reg & ~wb_dat_i[`HDBP_BIT_END];

  // ----------------------------------------------------------------
  // Direction and pin qualification
  // ----------------------------------------------------------------
  // Transmit wins if software sets both enables at once
  wire tx_sel = dma_enable_reg[`HDBP_BIT_TX_EN]; // [RQ1]
  wire rx_sel = dma_enable_reg[`HDBP_BIT_RX_EN] & ~tx_sel; // [RQ14]
  // Pin qualification ignores any register address while acknowledged
  wire wr_cycle = dma_ack & io_wr & tx_sel; // [RQ21] [RQ2]
  wire rd_cycle = dma_ack & io_rd & rx_sel; // [RQ21] [RQ15]
  wire eop_act = dma_end_status ^ config_reg[`HDBP_BIT_EOP_POL]; // [RQ3]

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  logic wf_in_ready, wf_out_valid, rf_in_ready, rf_out_valid;
  logic [DW-1:0] wf_out_data, rf_out_data;
  wire wr_push = wr_cycle & ~wr_taken_reg & wf_in_ready; // [RQ4]
  wire rd_load = rd_cycle & ~rd_loaded_reg & rf_out_valid;
  wire rd_pop = rd_loaded_reg & ~io_rd; // [RQ16]
  wire xfer_done = wr_push | rd_pop;
  wire end_event = xfer_done & (eop_seen_reg | (dma_ack & eop_act)); // [RQ7] [RQ20]
  wire rd_issue = rx_sel & rx_packet_waiting & rf_in_ready & ~buf_rd_en_reg;

  hdbp_fifo #(.W(DW), .AW(FAW)) u_wr_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .flush(1'b0),
    .in_valid(wr_push),
    .in_ready(wf_in_ready),
    .in_data(host_data_in),
    .out_valid(wf_out_valid),
    .out_ready(1'b1),
    .out_data(wf_out_data)
  );

  hdbp_fifo #(.W(DW), .AW(FAW)) u_rd_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .flush(dma_reset),
    .in_valid(buf_rd_en_reg),
    .in_ready(rf_in_ready),
    .in_data(buf_rd_data),
    .out_valid(rf_out_valid),
    .out_ready(rd_pop),
    .out_data(rf_out_data)
  );

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  hdbp_seq_if sq();
  wire src_ok = tx_sel ? wf_in_ready : (rx_sel & rf_out_valid);
  assign sq.can_go = src_ok & ~dma_end_status_reg; // [RQ1] [RQ7] [RQ14]
  assign sq.burst_len = dma_burst_reg; // [RQ6]
  assign sq.extend = request_extend_reg;
  assign sq.xfer_done = xfer_done;
  assign sq.flush = dma_reset; // [RQ9] [RQ19]
  assign sq.dma_ack = dma_ack;

  hdbp_burst_seq u_seq (
    .clock(clock),
    .sys_rst(sys_rst),
    .sq(sq.seq)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire rdy_act = tx_sel ? (wr_taken_reg & wr_cycle) : (rd_loaded_reg & rd_cycle);
  assign chan_ready = rdy_act ^ config_reg[`HDBP_BIT_RDY_POL]; // [RQ3] [RQ15]
  assign dma_req = sq.dreq; // [RQ2] [RQ15]
  assign host_data_out = host_data_reg;
  assign host_data_oe = rd_cycle;
  assign buf_wr_en = buf_wr_en_reg;
  assign buf_wr_addr = buf_wr_addr_reg;
  assign buf_wr_data = buf_wr_data_reg;
  assign buf_rd_en = buf_rd_en_reg;
  assign buf_rd_addr = buf_rd_addr_reg;
  assign tx_start = tx_start_reg;
  assign transmit_packet_count = tx_count_reg;
  assign dma_end_irq = dma_end_status_reg & dma_end_int_enable_reg; // [RQ8]
  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (hit_en) begin
      rd_mux[`HDBP_BIT_TX_EN] = dma_enable_reg[`HDBP_BIT_TX_EN];
      rd_mux[`HDBP_BIT_RX_EN] = dma_enable_reg[`HDBP_BIT_RX_EN];
    end
    if (hit_burst) rd_mux[1:0] = dma_burst_reg;
    if (hit_txs) rd_mux[6:0] = tx_count_reg;
    if (hit_stat) rd_mux[`HDBP_BIT_END] = dma_end_status_reg;
    if (hit_ien) rd_mux[`HDBP_BIT_END] = dma_end_int_enable_reg;
    if (hit_txm) rd_mux[`HDBP_BIT_EXTEND] = request_extend_reg;
    if (hit_rxm) rd_mux[`HDBP_BIT_RX_EMPTY] = ~rx_packet_waiting; // [RQ12]
    if (hit_cfg) rd_mux[1:0] = config_reg;
  end

  // ----------------------------------------------------------------
  // Wishbone slave: one wait state, ack for one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= '0;
    end else begin
      wb_ack_reg <= wb_take;
      if (wb_take) wb_dat_reg <= wb_we_i ? '0 : rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dma_enable_reg <= `HDBP_RST_EN;
      dma_burst_reg <= `HDBP_RST_BURST;
      tx_count_reg <= `HDBP_RST_COUNT;
      tx_start_reg <= 1'b0;
      dma_end_int_enable_reg <= 1'b0;
      request_extend_reg <= 1'b0;
      config_reg <= `HDBP_RST_CFG;
    end else begin
      if (en_write) dma_enable_reg <= en_wdat;
      if (wb_wr & hit_burst) dma_burst_reg <= wb_dat_i[1:0];
      if (wb_wr & hit_txs) tx_count_reg <= wb_dat_i[6:0]; // [RQ11]
      // Start is a self-clearing command pulse
      tx_start_reg <= wb_wr & hit_txs & wb_dat_i[`HDBP_BIT_TX_START]; // [RQ11]
      if (wb_wr & hit_ien) dma_end_int_enable_reg <= wb_dat_i[`HDBP_BIT_END];
      if (wb_wr & hit_txm) request_extend_reg <= wb_dat_i[`HDBP_BIT_EXTEND];
      if (wb_wr & hit_cfg) config_reg <= wb_dat_i[1:0];
    end
  end

  // ----------------------------------------------------------------
  // End-of-process tracking; an end status set in the clearing cycle survives
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dma_end_status_reg <= 1'b0;
      eop_seen_reg <= 1'b0;
    end else begin
      dma_end_status_reg <= end_event | (dma_end_status_reg & ~(dma_reset | ien_fall)); // [RQ7] [RQ9] [RQ10]
      // Held until the cycle in progress completes
      if (dma_reset | xfer_done) eop_seen_reg <= 1'b0; // [RQ20]
      else if (dma_ack & eop_act) eop_seen_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Host cycle tracking and data return
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_taken_reg <= 1'b0;
      rd_loaded_reg <= 1'b0;
      host_data_reg <= '0;
    end else begin
      wr_taken_reg <= wr_cycle & (wr_taken_reg | wr_push); // [RQ4]
      if (rd_pop | dma_reset) rd_loaded_reg <= 1'b0; // [RQ16]
      else if (rd_load) rd_loaded_reg <= 1'b1;
      if (rd_load) host_data_reg <= rf_out_data; // [RQ15]
    end
  end

  // ----------------------------------------------------------------
  // Packet buffer side; pointers persist across DMA resets
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      buf_wr_en_reg <= 1'b0;
      buf_wr_addr_reg <= '0;
      buf_wr_data_reg <= '0;
      buf_rd_en_reg <= 1'b0;
      buf_rd_addr_reg <= '0;
    end else begin
      buf_wr_en_reg <= wf_out_valid; // [RQ4]
      if (wf_out_valid) buf_wr_data_reg <= wf_out_data;
      if (buf_wr_en_reg) buf_wr_addr_reg <= buf_wr_addr_reg + 1'b1;
      // One read in flight keeps the FIFO from overrunning
      buf_rd_en_reg <= rd_issue; // [RQ16]
      if (buf_rd_en_reg) buf_rd_addr_reg <= buf_rd_addr_reg + 1'b1; // [RQ16]
    end
  end
endmodule // hdbp_top
`default_nettype wire

// ===== rtl/hdbp_params.svh
// Constants for the host DMA buffer port: register map, field positions, reset values.
// How it works
// RQ1: Transmit enable bit gates transmit DMA requests.
// RQ2: Transmit: request, host acks, strobes, drives data.
// RQ3: Ready output; ready and end polarities configurable.
// RQ4: Written data goes via write FIFO to buffer.
// RQ5: Transmit burst drops request before last two cycles.
// RQ6: Burst holds 1, 4, 8 or 12 transfers.
// RQ7: End with last cycle sets status, stops requests.
// RQ8: End interrupt only when its enable is set.
// RQ9: Clearing transmit enable resets DMA, clears interrupt.
// RQ10: Clearing end interrupt enable clears status too.
// RQ11: Packet count plus start bit launches transmission.
// RQ12: Receive buffer empty reads 0 while packets wait.
// RQ13: Host reads receive header before programming DMA.
// RQ14: Receive enable bit gates receive DMA requests.
// RQ15: Receive: request, ack, read strobe, ready with data.
// RQ16: Read strobe end pops FIFO, advances read pointer.
// RQ17: Receive burst drops request two cycles early.
// RQ18: Host toggles receive enable between packets.
// RQ19: Writing zero to both enables resets DMA.
// RQ20: End takes effect after current cycle completes.
// RQ21: Under acknowledge, access goes to buffer port.
// RQ22: Burst codes 00/01/10/11 mean 1/4/8/12.
`ifndef HDBP_PARAMS_SVH
`define HDBP_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define HDBP_OFS_DMA_ENABLE 8'h00
`define HDBP_OFS_DMA_BURST 8'h04
`define HDBP_OFS_TX_START 8'h08
`define HDBP_OFS_RX_STATUS 8'h0C
`define HDBP_OFS_RX_INT_EN 8'h10
`define HDBP_OFS_TX_MODE 8'h14
`define HDBP_OFS_RX_MODE 8'h18
`define HDBP_OFS_CONFIG 8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HDBP_BIT_TX_EN 0
`define HDBP_BIT_RX_EN 1
`define HDBP_BIT_TX_START 7
`define HDBP_BIT_END 5
`define HDBP_BIT_EXTEND 2
`define HDBP_BIT_RX_EMPTY 6
`define HDBP_BIT_EOP_POL 0
`define HDBP_BIT_RDY_POL 1

// ----------------------------------------------------------------
// Burst codes and lengths
// ----------------------------------------------------------------
`define HDBP_BL_CODE_1 2'h0
`define HDBP_BL_CODE_4 2'h1
`define HDBP_BL_CODE_8 2'h2
`define HDBP_BL_LEN_1 4'h1
`define HDBP_BL_LEN_4 4'h4
`define HDBP_BL_LEN_8 4'h8
`define HDBP_BL_LEN_12 4'hC
`define HDBP_EARLY_DROP 4'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HDBP_RST_EN 2'h0
`define HDBP_RST_BURST 2'h0
`define HDBP_RST_COUNT 7'h00
`define HDBP_RST_CFG 2'h0

`endif

// ===== rtl/hdbp_pkg.sv
// Types and the burst-length decode function shared by the host DMA buffer port modules.
`default_nettype none
package hdbp_pkg;
`include "hdbp_params.svh"

  typedef enum logic [1:0] {HDBP_IDLE, HDBP_BURST, HDBP_CLOSE} hdbp_seq_e;
  typedef logic [1:0] hdbp_blen_t;

  function automatic logic [3:0] hdbp_blen(input hdbp_blen_t code);
    logic [3:0] len;
    len = `HDBP_BL_LEN_12;
    if (code == `HDBP_BL_CODE_1) len = `HDBP_BL_LEN_1;
    else if (code == `HDBP_BL_CODE_4) len = `HDBP_BL_LEN_4;
    else if (code == `HDBP_BL_CODE_8) len = `HDBP_BL_LEN_8;
    return len;
  endfunction
endpackage
`default_nettype wire

// ===== rtl/hdbp_seq_if.sv
// Signals between the port logic and its burst sequencer.
`timescale 1ns/10ps
`default_nettype none
interface hdbp_seq_if;
  logic can_go;
  logic [1:0] burst_len;
  logic extend;
  logic xfer_done;
  logic flush;
  logic dma_ack;
  logic dreq;
  modport ctl(output can_go, burst_len, extend, xfer_done, flush, dma_ack, input dreq);
  modport seq(input can_go, burst_len, extend, xfer_done, flush, dma_ack, output dreq);
endinterface
`default_nettype wire

// ===== rtl/hdbp_fifo.sv
// Small synchronous FIFO with first-word fall-through head.
`timescale 1ns/10ps
`default_nettype none
module hdbp_fifo #(
  parameter int W = 16,
  parameter int AW = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [0:(1<<AW)-1];
  logic [AW:0] wp_reg;
  logic [AW:0] rp_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] full_gap = {1'b1, {AW{1'b0}}};

  assign in_ready = (wp_reg ^ rp_reg) != full_gap;
  assign out_valid = wp_reg != rp_reg;
  assign out_data = mem[rp_reg[AW-1:0]];

  always_ff @(posedge clock) begin
    if (push) mem[wp_reg[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else if (flush) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop) rp_reg <= rp_reg + 1'b1;
    end
  end
endmodule // hdbp_fifo
`default_nettype wire

// ===== rtl/hdbp_burst_seq.sv
// Burst sequencer: counts transfers per burst and shapes the DMA request.
`timescale 1ns/10ps
`default_nettype none
`include "hdbp_params.svh"
module hdbp_burst_seq
  import hdbp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Control from the port logic
  hdbp_seq_if.seq sq
);
  hdbp_seq_e state_reg, state_next;
  logic [3:0] count_reg, count_next;
  logic [3:0] count_inc;
  wire [3:0] blen = hdbp_blen(sq.burst_len); // [RQ6] [RQ22]
  // Without the extend bit the request falls while the last two cycles run
  wire [3:0] early = (blen >= `HDBP_EARLY_DROP) ? blen - `HDBP_EARLY_DROP : '0;
  wire [3:0] drop_at = sq.extend ? blen : early; // [RQ5] [RQ17]

  assign count_inc = count_reg + 1'b1;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    unique case (state_reg)
      HDBP_IDLE: begin
        if (sq.dma_ack) begin
          state_next = HDBP_BURST;
          count_next = sq.xfer_done ? 4'h1 : 4'h0;
        end
      end
      HDBP_BURST: begin
        if (sq.xfer_done) count_next = count_inc;
        if (count_next >= blen) state_next = HDBP_CLOSE;
        else if (!sq.dma_ack && !sq.xfer_done) state_next = HDBP_IDLE;
      end
      HDBP_CLOSE: begin
        // Hold off until the host lets go of the acknowledge
        if (!sq.dma_ack) state_next = HDBP_IDLE; // [RQ5] [RQ17]
      end
    endcase
  end

  always_comb begin
    sq.dreq = 1'b0;
    unique case (state_reg)
      HDBP_IDLE: sq.dreq = sq.can_go;
      HDBP_BURST: sq.dreq = sq.can_go & (count_reg < drop_at); // [RQ5] [RQ17]
      HDBP_CLOSE: sq.dreq = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= HDBP_IDLE;
      count_reg <= '0;
    end else if (sq.flush) begin
      state_reg <= HDBP_IDLE;
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end
endmodule // hdbp_burst_seq
`default_nettype wire

// ===== test/hdbp_checker.sv
// Concurrent checks on the host DMA buffer port pins.
`timescale 1ns/10ps
`default_nettype none
module hdbp_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // DMA pins and controller side
  input wire logic dma_req,
  input wire logic dma_ack,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic dma_end_status,
  input wire logic chan_ready,
  input wire logic host_data_oe,
  input wire logic rx_packet_waiting,
  input wire logic tx_start,
  input wire logic [6:0] transmit_packet_count,
  input wire logic dma_end_irq
);
  // ----
  // Enable mirrors rebuilt from bus writes
  // ----
  logic wr_take;
  logic rd_done;
  logic [1:0] en_q;
  logic ie_q;
  assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign rd_done = wb_ack_o && !wb_we_i;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      en_q <= 2'h0;
      ie_q <= 1'h0;
    end else begin
      if (wr_take && wb_adr_i == 8'h00) en_q <= wb_dat_i[1:0];
      if (wr_take && wb_adr_i == 8'h10) ie_q <= wb_dat_i[5];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence bus_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence end_xfer;
    dma_ack && dma_end_status && chan_ready ##1 !io_wr && !io_rd;
  endsequence
  bus_ack_a: assert property (bus_take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle pulse");
  req_off_a: assert property (en_q == 2'h0 && $past(en_q) == 2'h0 |-> !dma_req)
    else $error("request while both enables clear");
  ready_cause_a: assert property ($rose(chan_ready) |-> dma_ack && (io_wr || io_rd))
    else $error("ready without an acknowledged strobe");
  end_stop_a: assert property (end_xfer |-> ##2 !dma_req [*5])
    else $error("request after end of process");
  irq_gate_a: assert property (dma_end_irq |-> ie_q || $past(ie_q))
    else $error("end interrupt while disabled");
  drive_gate_a: assert property (host_data_oe |-> dma_ack && io_rd)
    else $error("data driven outside a read cycle");
  start_cause_a: assert property (tx_start |-> $past(wr_take && wb_adr_i == 8'h08 && wb_dat_i[7]))
    else $error("start pulse without start write");
  count_load_a: assert property (wr_take && wb_adr_i == 8'h08 |=> transmit_packet_count == $past(wb_dat_i[6:0]))
    else $error("packet count not loaded");
  empty_flag_a: assert property (rd_done && wb_adr_i == 8'h18 |-> wb_dat_o[6] == !$past(rx_packet_waiting))
    else $error("empty flag wrong");
  unmapped_a: assert property (rd_done && wb_adr_i > 8'h1F |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule // hdbp_checker
`default_nettype wire

// ===== test/hdbp_host_model.sv
// Behavioural host DMA controller on the port's DMA pins.
`timescale 1ns/10ps
`default_nettype none
module hdbp_host_model (
  // Bench control
  input wire logic clock,
  input wire logic p_go,
  input wire logic p_rd,
  input wire logic [3:0] p_n,
  input wire logic p_eop,
  input wire logic [15:0] p_base,
  input wire logic [3:0] p_gap,
  output logic p_busy,
  output logic p_got,
  output logic [15:0] p_data,
  // DMA pins
  input wire logic dma_req,
  input wire logic chan_ready,
  input wire logic [15:0] host_data_out,
  output logic dma_ack,
  output logic io_wr,
  output logic io_rd,
  output logic dma_end_status,
  output logic [15:0] host_data_in
);
  int i;
  int k;
  initial begin
    {p_busy, p_got, dma_ack, io_wr, io_rd, dma_end_status} = 6'h0;
    host_data_in = 16'h0;
    p_data = 16'h0;
    forever begin
      @(posedge clock);
      if (p_go && dma_req) begin
        p_busy <= 1'b1;
        dma_ack <= 1'b1;
        for (i = 0; i < p_n; i++) begin
          repeat (p_gap + 1) @(posedge clock) p_got <= 1'b0;
          io_wr <= !p_rd;
          io_rd <= p_rd;
          dma_end_status <= p_eop && (i == p_n - 1);
          host_data_in <= p_base + 16'(i);
          k = 0;
          do @(posedge clock) k++; while (chan_ready !== 1'b1 && k < 40);
          p_got <= p_rd;
          p_data <= host_data_out;
          {io_wr, io_rd, dma_end_status} <= 3'h0;
          // Released lines must not keep looking valid
          host_data_in <= ~host_data_in;
        end
        // Whole burst done before the acknowledge goes
        @(posedge clock);
        p_got <= 1'b0;
        dma_ack <= 1'b0;
        p_busy <= 1'b0;
      end
    end
  end
endmodule // hdbp_host_model
`default_nettype wire

// ===== test/test_host_dma_buffer_port.sv
// Self-checking bench for the host DMA buffer port.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("Error %0t: %h vs %h", $time, a, b); end end
module test_host_dma_buffer_port;
  logic clock, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dma_req, dma_ack, io_wr, io_rd, dma_end_status;
  logic chan_ready, host_data_oe, buf_wr_en, buf_rd_en, rx_packet_waiting, tx_start, dma_end_irq;
  logic p_go, p_rd, p_eop, p_busy, p_got;
  logic [7:0] wb_adr_i, e8;
  logic [3:0] wb_sel_i, p_n, p_gap;
  logic [31:0] wb_dat_i, wb_dat_o, seed;
  logic [15:0] host_data_in, host_data_out, buf_wr_data, buf_rd_data, buf_wr_addr, buf_rd_addr;
  logic [15:0] p_base, p_data, e16, ra, wa;
  logic [6:0] transmit_packet_count;
  logic [7:0] rq[$];
  logic [15:0] tq[$], xq[$], mq[$];
  logic [7:0] ofs[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h40};
  logic [7:0] rv[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00};
  int blen[4] = '{1, 4, 8, 12};
  int fails, compares, starts;
  hdbp_top i_dut (.*);
  hdbp_host_model i_host (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic lost();
    fails++;
    summarize();
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [7:0] e);
    int k;
    k = 0;
    if (!w) rq.push_back(e);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clock) k++; while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) lost();
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask
  // Host length comes from the bench's own table, as a host would program it
  task automatic burst(input logic r, input logic [1:0] c, input logic e);
    int k;
    k = 0;
    p_rd <= r;
    p_n <= 4'(blen[c]);
    p_eop <= e;
    p_gap <= seed[3:0] & 4'h3;
    p_base <= seed[15:0];
    for (int i = 0; i < blen[c]; i++) if (!r) tq.push_back(seed[15:0] + 16'(i));
    seed = xs(seed);
    p_go <= 1'b1;
    do @(posedge clock) k++; while (p_busy !== 1'b1 && k < 60);
    if (k >= 60) lost();
    p_go <= 1'b0;
    do @(posedge clock) k++; while (p_busy !== 1'b0 && k < 400);
    if (k >= 400) lost();
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (30000) @(posedge clock);
    lost();
  end
  // ----
  // Result watcher and buffer memory
  // ----
  always @(posedge clock) begin
    // Buffer read is combinational: the word must stand while the read strobe is up
    if (buf_rd_en === 1'b1) begin
      `CHK(buf_rd_addr, ra)
      ra++;
      if (mq.size() > 0) void'(mq.pop_front());
    end
    buf_rd_data <= (mq.size() > 0) ? mq[0] : ~buf_rd_data;
    if (tx_start === 1'b1) starts++;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rq.size() > 0) begin
      e8 = rq.pop_front();
      `CHK(wb_dat_o[7:0], e8)
    end
    if (buf_wr_en === 1'b1 && tq.size() > 0) begin
      e16 = tq.pop_front();
      `CHK(buf_wr_data, e16)
      `CHK(buf_wr_addr, wa)
      wa++;
    end
    if (p_got === 1'b1 && xq.size() > 0) begin
      e16 = xq.pop_front();
      `CHK(p_data, e16)
    end
  end
  initial begin
    {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, p_go, p_rd, p_eop, rx_packet_waiting} = 8'h80;
    {wb_adr_i, wb_dat_i, wb_sel_i, p_n, p_gap} = {8'h00, 32'h0, 4'hF, 4'h1, 4'h0};
    {buf_rd_data, p_base, ra, wa, seed} = {16'h0, 16'h0, 16'h0, 16'h0, 32'hDE0F};
    {fails, compares, starts} = {32'h0, 32'h0, 32'h0};
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    for (int j = 0; j < 9; j++) wb(1'b0, ofs[j], 32'h0, rv[j]);
    wb(1'b1, 8'h00, 32'h1, 8'h0);
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, 8'h04, 32'(c), 8'h0);
      wb(1'b0, 8'h04, 32'h0, 8'(c));
      wb(1'b1, 8'h14, 32'(c % 2) << 2, 8'h0);
      burst(1'b0, 2'(c), 1'b0);
    end
    wb(1'b1, 8'h04, 32'h1, 8'h0);
    burst(1'b0, 2'h1, 1'b1);
    wb(1'b0, 8'h0C, 32'h0, 8'h20);
    `CHK(dma_end_irq, 1'b0)
    wb(1'b1, 8'h10, 32'h20, 8'h0);
    `CHK(dma_end_irq, 1'b1)
    wb(1'b1, 8'h10, 32'h0, 8'h0);
    wb(1'b0, 8'h0C, 32'h0, 8'h00);
    wb(1'b1, 8'h10, 32'h20, 8'h0);
    burst(1'b0, 2'h1, 1'b1);
    wb(1'b0, 8'h0C, 32'h0, 8'h20);
    `CHK(dma_end_irq, 1'b1)
    wb(1'b1, 8'h00, 32'h0, 8'h0);
    wb(1'b0, 8'h0C, 32'h0, 8'h00);
    `CHK(dma_end_irq, 1'b0)
    wb(1'b1, 8'h08, 32'h85, 8'h0);
    `CHK(transmit_packet_count, 7'h05)
    wb(1'b0, 8'h08, 32'h0, 8'h05);
    rx_packet_waiting <= 1'b1;
    wb(1'b0, 8'h18, 32'h0, 8'h00);
    for (int j = 0; j < 4; j++) begin
      mq.push_back(seed[15:0]);
      xq.push_back(seed[15:0]);
      seed = xs(seed);
    end
    wb(1'b1, 8'h00, 32'h2, 8'h0);
    burst(1'b1, 2'h1, 1'b1);
    wb(1'b1, 8'h00, 32'h0, 8'h0);
    repeat (10) @(posedge clock);
    `CHK(dma_req, 1'b0)
    `CHK(starts, 1)
    `CHK(tq.size() + xq.size(), 0)
    summarize();
  end
endmodule // test_host_dma_buffer_port
bind hdbp_top hdbp_checker i_chk (.*);
`default_nettype wire
